//--- core/twm_evt_status.sv
// sticky event status with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module twm_evt_status #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	// events and clearing
	input  wire logic [WIDTH-1:0] evt_set,
	input  wire logic [WIDTH-1:0] evt_clr,
	// state
	output var  logic [WIDTH-1:0] status
);
	logic [WIDTH-1:0] status_reg;
	logic [WIDTH-1:0] status_next;

	always_comb begin
		// set wins over clear
		status_next = (status_reg & ~evt_clr) | evt_set;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	assign status = status_reg;
endmodule : twm_evt_status
`default_nettype wire

//--- core/twm_irq_enable.sv
// interrupt enable registers of the two-wire master, AHB-Lite slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module twm_irq_enable (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// event pulses from the engine
	input  wire logic        halted_event,
	input  wire logic        error_event,
	input  wire logic        paused_event,
	input  wire logic        receive_begun_event,
	input  wire logic        transmit_begun_event,
	input  wire logic        final_receive_byte_event,
	input  wire logic        final_transmit_byte_event,
	// interrupt
	output logic             irq
);
	////////////////////////////////////////////////////////////////////
	typedef enum logic [0:0] {
		PH_IDLE  = 1'b0,
		PH_WRITE = 1'b1
	} phase_t;

	phase_t      phase_reg;
	phase_t      phase_next;
	logic [11:0] waddr_reg;
	logic [11:0] waddr_next;
	logic [31:0] enable_reg;
	logic [31:0] enable_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        irq_reg;
	logic        irq_next;
	logic [31:0] evt_vec;
	logic [31:0] evt_clr;
	logic [31:0] status;
	logic        addr_ok;
	logic        wr_ok;
	logic [31:0] wr_bits;
	logic        hreadyout_reg;
	logic        hreadyout_next;
	logic        hresp_reg;
	logic        hresp_next;

	function automatic logic [31:0] read_word(input logic [11:0] a,
		input logic [31:0] en, input logic [31:0] st);
		case (a)
			twm_irq_pkg::OFF_ENABLE_MASK,
			twm_irq_pkg::OFF_ENABLE_SET,
			twm_irq_pkg::OFF_ENABLE_CLEAR: read_word = en;
			twm_irq_pkg::OFF_EVT_STATUS:   read_word = st;
			default:                       read_word = 32'h0000_0000;
		endcase
	endfunction : read_word

	////////////////////////////////////////////////////////////////////
	// event vector, one bit per event field
	always_comb begin
		evt_vec = 32'h0000_0000;
		evt_vec[twm_irq_pkg::BIT_HALTED]   = halted_event;
		evt_vec[twm_irq_pkg::BIT_ERROR]    = error_event;
		evt_vec[twm_irq_pkg::BIT_PAUSED]   = paused_event;
		evt_vec[twm_irq_pkg::BIT_RX_BEGUN] = receive_begun_event;
		evt_vec[twm_irq_pkg::BIT_TX_BEGUN] = transmit_begun_event;
		evt_vec[twm_irq_pkg::BIT_LAST_RX]  = final_receive_byte_event;
		evt_vec[twm_irq_pkg::BIT_LAST_TX]  = final_transmit_byte_event;
	end

	assign addr_ok = hsel && hready && (htrans == twm_irq_pkg::HTRANS_NONSEQ);
	assign wr_ok   = (phase_reg == PH_WRITE);
	assign wr_bits = hwdata & twm_irq_pkg::FIELD_MASK;
	assign evt_clr = (wr_ok && waddr_reg == twm_irq_pkg::OFF_EVT_CLEAR)
		? wr_bits : 32'h0000_0000;

	twm_evt_status #(
		.WIDTH(32)
	) u_status (
		.core_clk(core_clk),
		.arst_n  (arst_n),
		.evt_set (evt_vec),
		.evt_clr (evt_clr),
		.status  (status)
	);

	////////////////////////////////////////////////////////////////////
	// bus phases and enable register
	always_comb begin
		phase_next  = PH_IDLE;
		waddr_next  = waddr_reg;
		enable_next = enable_reg;
		rdata_next  = rdata_reg;
		hreadyout_next = 1'b1;
		hresp_next     = 1'b0;
		if (wr_ok) begin
			case (waddr_reg)
				twm_irq_pkg::OFF_ENABLE_MASK:
					enable_next = wr_bits;
				twm_irq_pkg::OFF_ENABLE_SET:
					enable_next = enable_reg | wr_bits;
				twm_irq_pkg::OFF_ENABLE_CLEAR:
					enable_next = enable_reg & ~wr_bits;
				default:
					enable_next = enable_reg;
			endcase
		end
		if (addr_ok) begin
			waddr_next = haddr;
			if (hwrite) begin
				phase_next = PH_WRITE;
			end else begin
				rdata_next = read_word(haddr, enable_next, status);
			end
		end
	end

	// one interrupt line, each event gated by its own enable
	always_comb begin
		irq_next = |(status & enable_reg);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg  <= PH_IDLE;
			waddr_reg  <= 12'h000;
			enable_reg <= twm_irq_pkg::ENABLE_RESET;
			rdata_reg  <= 32'h0000_0000;
			irq_reg    <= 1'b0;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end else begin
			phase_reg  <= phase_next;
			waddr_reg  <= waddr_next;
			enable_reg <= enable_next;
			rdata_reg  <= rdata_next;
			irq_reg    <= irq_next;
			hreadyout_reg <= hreadyout_next;
			hresp_reg     <= hresp_next;
		end
	end

	assign hrdata    = rdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp     = hresp_reg;
	assign irq       = irq_reg;

	////////////////////////////////////////////////////////////////////
	// checks
	property p_reset_zero;
		@(posedge core_clk)
		$rose(arst_n) |-> enable_reg == twm_irq_pkg::ENABLE_RESET;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("enables not zero after reset");

	property p_mask_write;
		@(posedge core_clk) disable iff (!arst_n)
		wr_ok && waddr_reg == twm_irq_pkg::OFF_ENABLE_MASK
		|=> enable_reg == ($past(hwdata) & twm_irq_pkg::FIELD_MASK);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask write not stored");

	property p_set_write;
		@(posedge core_clk) disable iff (!arst_n)
		wr_ok && waddr_reg == twm_irq_pkg::OFF_ENABLE_SET |=> enable_reg ==
			($past(enable_reg) | ($past(hwdata) & twm_irq_pkg::FIELD_MASK));
	endproperty
	a_set_write: assert property (p_set_write)
		else $error("set view write wrong");

	property p_clear_write;
		@(posedge core_clk) disable iff (!arst_n)
		wr_ok && waddr_reg == twm_irq_pkg::OFF_ENABLE_CLEAR |=> enable_reg ==
			($past(enable_reg) & ~$past(hwdata));
	endproperty
	a_clear_write: assert property (p_clear_write)
		else $error("clear view write wrong");

	property p_no_write_hold;
		@(posedge core_clk) disable iff (!arst_n)
		!wr_ok |=> $stable(enable_reg);
	endproperty
	a_no_write_hold: assert property (p_no_write_hold)
		else $error("enables changed without write");

	property p_read_set;
		@(posedge core_clk) disable iff (!arst_n)
		addr_ok && !hwrite && haddr == twm_irq_pkg::OFF_ENABLE_SET && !wr_ok
			|=> hrdata == $past(enable_reg);
	endproperty
	a_read_set: assert property (p_read_set)
		else $error("set view read wrong");

	property p_irq_error;
		@(posedge core_clk) disable iff (!arst_n)
		error_event && enable_reg[twm_irq_pkg::BIT_ERROR]
			##1 enable_reg[twm_irq_pkg::BIT_ERROR] |=> irq;
	endproperty
	a_irq_error: assert property (p_irq_error)
		else $error("error interrupt missing");

	property p_irq_gated;
		@(posedge core_clk) disable iff (!arst_n)
		(status & enable_reg) == 32'h0000_0000 |=> !irq;
	endproperty
	a_irq_gated: assert property (p_irq_gated)
		else $error("interrupt without enabled event");

	property p_irq_last_tx;
		@(posedge core_clk) disable iff (!arst_n)
		final_transmit_byte_event && enable_reg[twm_irq_pkg::BIT_LAST_TX]
			##1 enable_reg[twm_irq_pkg::BIT_LAST_TX] |=> irq;
	endproperty
	a_irq_last_tx: assert property (p_irq_last_tx)
		else $error("final transmit interrupt missing");

	property p_irq_halted;
		@(posedge core_clk) disable iff (!arst_n)
		halted_event && enable_reg[twm_irq_pkg::BIT_HALTED]
			##1 enable_reg[twm_irq_pkg::BIT_HALTED] |=> irq;
	endproperty
	a_irq_halted: assert property (p_irq_halted)
		else $error("halted interrupt missing");

	property p_irq_paused;
		@(posedge core_clk) disable iff (!arst_n)
		paused_event && enable_reg[twm_irq_pkg::BIT_PAUSED]
			##1 enable_reg[twm_irq_pkg::BIT_PAUSED] |=> irq;
	endproperty
	a_irq_paused: assert property (p_irq_paused)
		else $error("paused interrupt missing");

	property p_irq_rx_begun;
		@(posedge core_clk) disable iff (!arst_n)
		receive_begun_event && enable_reg[twm_irq_pkg::BIT_RX_BEGUN]
			##1 enable_reg[twm_irq_pkg::BIT_RX_BEGUN] |=> irq;
	endproperty
	a_irq_rx_begun: assert property (p_irq_rx_begun)
		else $error("receive begun interrupt missing");

	property p_irq_tx_begun;
		@(posedge core_clk) disable iff (!arst_n)
		transmit_begun_event && enable_reg[twm_irq_pkg::BIT_TX_BEGUN]
			##1 enable_reg[twm_irq_pkg::BIT_TX_BEGUN] |=> irq;
	endproperty
	a_irq_tx_begun: assert property (p_irq_tx_begun)
		else $error("transmit begun interrupt missing");

	property p_irq_last_rx;
		@(posedge core_clk) disable iff (!arst_n)
		final_receive_byte_event && enable_reg[twm_irq_pkg::BIT_LAST_RX]
			##1 enable_reg[twm_irq_pkg::BIT_LAST_RX] |=> irq;
	endproperty
	a_irq_last_rx: assert property (p_irq_last_rx)
		else $error("final receive interrupt missing");

	property p_read_mask;
		@(posedge core_clk) disable iff (!arst_n)
		addr_ok && !hwrite && haddr == twm_irq_pkg::OFF_ENABLE_MASK && !wr_ok
			|=> hrdata == $past(enable_reg);
	endproperty
	a_read_mask: assert property (p_read_mask)
		else $error("mask read wrong");

	property p_read_clear;
		@(posedge core_clk) disable iff (!arst_n)
		addr_ok && !hwrite && haddr == twm_irq_pkg::OFF_ENABLE_CLEAR && !wr_ok
			|=> hrdata == $past(enable_reg);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("clear view read wrong");

	property p_set_zero_hold;
		@(posedge core_clk) disable iff (!arst_n)
		wr_ok && waddr_reg == twm_irq_pkg::OFF_ENABLE_SET
			&& hwdata == 32'h0000_0000 |=> $stable(enable_reg);
	endproperty
	a_set_zero_hold: assert property (p_set_zero_hold)
		else $error("zero set write changed enables");

	property p_clear_zero_hold;
		@(posedge core_clk) disable iff (!arst_n)
		wr_ok && waddr_reg == twm_irq_pkg::OFF_ENABLE_CLEAR
			&& hwdata == 32'h0000_0000 |=> $stable(enable_reg);
	endproperty
	a_clear_zero_hold: assert property (p_clear_zero_hold)
		else $error("zero clear write changed enables");

	property p_status_last_tx;
		@(posedge core_clk) disable iff (!arst_n)
		final_transmit_byte_event |=> status[twm_irq_pkg::BIT_LAST_TX];
	endproperty
	a_status_last_tx: assert property (p_status_last_tx)
		else $error("final transmit event not latched");
endmodule : twm_irq_enable
`default_nettype wire

//--- core/twm_irq_pkg.sv
// constants for the two-wire master interrupt enable block
package twm_irq_pkg;
	localparam logic [11:0] OFF_ENABLE_MASK  = 12'h300;
	localparam logic [11:0] OFF_ENABLE_SET   = 12'h304;
	localparam logic [11:0] OFF_ENABLE_CLEAR = 12'h308;
	localparam logic [11:0] OFF_EVT_STATUS   = 12'h310;
	localparam logic [11:0] OFF_EVT_CLEAR    = 12'h314;
	localparam int          NUM_EVENTS       = 7;
	localparam int          BIT_HALTED       = 0;
	localparam int          BIT_ERROR        = 9;
	localparam int          BIT_PAUSED       = 18;
	localparam int          BIT_RX_BEGUN     = 19;
	localparam int          BIT_TX_BEGUN     = 20;
	localparam int          BIT_LAST_RX      = 23;
	localparam int          BIT_LAST_TX      = 24;
	localparam logic [31:0] ENABLE_RESET     = 32'h0000_0000;
	localparam logic [31:0] FIELD_MASK       = 32'h019C_0201;
	localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
	localparam logic [1:0]  HSIZE_WORD       = 2'h2;
endpackage : twm_irq_pkg

//--- verification/irq_sink_model.sv
// processor interrupt input model at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module irq_sink_model (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	// interrupt line and its pending state
	input  wire logic irq,
	output var  logic pending
);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			pending <= 1'b0;
		else
			pending <= irq;
	end
endmodule : irq_sink_model
`default_nettype wire

//--- verification/tb_two_wire_master_irq_enable.sv
// self-checking bench of the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_master_irq_enable;
	logic        core_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic        irq, pending;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic [6:0]  ev;
	int          miscompares, num_checks, cycles;
	int          bits[7];
	assign hready = hreadyout;
	twm_irq_enable uut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .halted_event(ev[0]),
		.error_event(ev[1]), .paused_event(ev[2]),
		.receive_begun_event(ev[3]), .transmit_begun_event(ev[4]),
		.final_receive_byte_event(ev[5]),
		.final_transmit_byte_event(ev[6]), .irq(irq));
	irq_sink_model sink (.core_clk(core_clk), .arst_n(arst_n), .irq(irq),
		.pending(pending));
	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task final_report;
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel   <= 1'b1;
		htrans <= twm_irq_pkg::HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= w;
		hsize  <= {1'b0, twm_irq_pkg::HSIZE_WORD};
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask : bus
	task pulse(input logic [6:0] m);
		@(posedge core_clk);
		ev <= m;
		@(posedge core_clk);
		ev <= 7'h00;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		bits = '{twm_irq_pkg::BIT_HALTED, twm_irq_pkg::BIT_ERROR,
			twm_irq_pkg::BIT_PAUSED, twm_irq_pkg::BIT_RX_BEGUN,
			twm_irq_pkg::BIT_TX_BEGUN, twm_irq_pkg::BIT_LAST_RX,
			twm_irq_pkg::BIT_LAST_TX};
		{arst_n, hsel, hwrite, ev, haddr, htrans, hsize, hwdata} = '0;
		{miscompares, num_checks, cycles} = '0;
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 3; a++) begin
			bus(1'b0, twm_irq_pkg::OFF_ENABLE_MASK + 12'(4 * a), 32'h0);
			check(rd, twm_irq_pkg::ENABLE_RESET);
		end
		bus(1'b1, twm_irq_pkg::OFF_ENABLE_MASK, 32'hFFFF_FFFF);
		bus(1'b0, twm_irq_pkg::OFF_ENABLE_MASK, 32'h0);
		check(rd, twm_irq_pkg::FIELD_MASK);
		bus(1'b1, twm_irq_pkg::OFF_ENABLE_CLEAR, 32'h0000_0201);
		bus(1'b1, twm_irq_pkg::OFF_ENABLE_SET, 32'h0);
		bus(1'b0, twm_irq_pkg::OFF_ENABLE_SET, 32'h0);
		check(rd, 32'h019C_0000);
		bus(1'b0, twm_irq_pkg::OFF_ENABLE_CLEAR, 32'h0);
		check(rd, 32'h019C_0000);
		bus(1'b1, twm_irq_pkg::OFF_ENABLE_MASK, 32'h0);
		bus(1'b1, twm_irq_pkg::OFF_ENABLE_SET, 32'h0000_0200);
		bus(1'b1, twm_irq_pkg::OFF_ENABLE_CLEAR, 32'h0);
		bus(1'b0, twm_irq_pkg::OFF_ENABLE_MASK, 32'h0);
		check(rd, 32'h0000_0200);
		bus(1'b0, 12'h0FC, 32'h0);
		check(rd, 32'h0);
		for (int e = 0; e < 7; e++) begin
			bus(1'b1, twm_irq_pkg::OFF_ENABLE_MASK, 32'h1 << bits[e]);
			bus(1'b1, twm_irq_pkg::OFF_EVT_CLEAR, 32'hFFFF_FFFF);
			pulse(~(7'h01 << e));
			check({31'h0, irq}, 32'h0);
			pulse(7'h01 << e);
			check({30'h0, irq, pending}, 32'h3);
			bus(1'b0, twm_irq_pkg::OFF_EVT_STATUS, 32'h0);
			check(rd, twm_irq_pkg::FIELD_MASK);
			bus(1'b1, twm_irq_pkg::OFF_EVT_CLEAR, 32'hFFFF_FFFF);
			repeat (2) @(posedge core_clk);
			#1;
			check({31'h0, irq}, 32'h0);
			bus(1'b0, twm_irq_pkg::OFF_EVT_STATUS, 32'h0);
			check(rd, 32'h0);
		end
		final_report();
	end
endmodule : tb_two_wire_master_irq_enable
`default_nettype wire
